// ### dv/ssp_host_model.sv
`timescale 1ns/1ps
`default_nettype none
// apb master standing in for the flash host controller
module ssp_host_model (
  input  wire logic        clock,   // 100 MHz
  input  wire logic        rst,     // sync reset
  input  wire logic        req,     // start one transfer
  input  wire logic        wr,      // direction
  input  wire logic [11:0] addr,    // byte address
  input  wire logic [31:0] wdata,   // write data
  input  wire logic [31:0] prdata,  // apb read data
  input  wire logic        pready,  // apb ready
  input  wire logic        pslverr, // apb error
  output logic             psel,    // apb select
  output logic             penable, // apb enable
  output logic             pwrite,  // apb direction
  output logic      [11:0] paddr,   // apb address
  output logic      [31:0] pwdata,  // apb write data
  output logic             done,    // transfer finished
  output logic      [31:0] rdata,   // captured read data
  output logic             err      // captured error
);
  // reset clears every output, so a single process drives each one
  always_ff @(posedge clock) begin
    done <= !rst && psel && penable && pready;
    if (rst) begin
      psel <= 1'b0;
      penable <= 1'b0;
      pwrite <= 1'b0;
      paddr <= '0;
      pwdata <= '0;
      rdata <= '0;
      err <= 1'b0;
    end else if (!psel) begin
      if (req) begin
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= addr;
        pwdata <= wdata;
      end
    end else if (!penable) begin
      penable <= 1'b1;
    end else if (pready) begin
      psel <= 1'b0;
      penable <= 1'b0;
      rdata <= prdata;
      err <= pslverr;
      // released lines must not keep looking valid
      paddr <= ~paddr;
      pwdata <= ~pwdata;
    end
  end
endmodule
`default_nettype wire

// ### dv/tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "ssp_defines.svh"
module tb;
  import ssp_pkg::*;
  localparam logic [127:0] RND = 128'h00112233445566778899aabbccddeeff;
  localparam logic [63:0]  PW  = 64'h1234_5678_9abc_def0;
  typedef struct {logic [15:0] pa; logic [7:0] d; logic [9:0] ra;
    logic [7:0] e; logic pe;} ssp_row_t;
  ssp_row_t rows [7] = '{
    '{16'h0000, 8'h00, 10'h000, RND[7:0], 1'b1},
    '{16'h0020, 8'h5a, 10'h020, 8'h5a, 1'b0},
    '{16'h0020, 8'h0f, 10'h020, 8'h0a, 1'b0},
    '{16'h0415, 8'h33, 10'h015, 8'h33, 1'b0},
    '{16'h03ff, 8'hff, 10'h3ff, 8'hff, 1'b0},
    '{16'h0010, 8'hfd, 10'h010, 8'hfd, 1'b0},
    '{16'h0021, 8'h00, 10'h021, 8'hff, 1'b0}};
  logic clock = 0, rst = 1, por = 1, req = 0, wr = 0;
  logic [11:0] ad = '0, paddr;
  logic [31:0] wd = '0, pwdata, prdata, hr;
  logic psel, penable, pwrite, pready, pslverr, done, herr, arr_grant;
  logic [5:0] arr_sector, gsec;
  int fail_count = 0, compares = 0, gcnt = 0, cyc = 0;
  always #5 clock = ~clock;
  ssp_protect #(.RAND_NUM(RND), .HIDDEN_PW(PW)) ssp_protect_inst (
    .clock(clock), .rst(rst), .por(por), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .arr_grant(arr_grant),
    .arr_sector(arr_sector));
  ssp_host_model ssp_host_model_inst (
    .clock(clock), .rst(rst), .req(req), .wr(wr), .addr(ad), .wdata(wd),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .done(done), .rdata(hr), .err(herr));
  always @(posedge clock) begin
    cyc++;
    if (arr_grant === 1'b1) begin
      gcnt++;
      gsec = arr_sector;
    end
    if (cyc > 20000) begin
      fail_count++;
      tally_and_finish();
    end
  end
  task tally_and_finish();
    $display("compares %0d mismatches %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e) begin
      fail_count++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask
  task op(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    req <= 1'b1;
    wr <= w;
    ad <= a;
    wd <= d;
    @(posedge clock);
    req <= 1'b0;
    do begin
      @(posedge clock);
      n++;
    end while (done !== 1'b1 && n < 50);
    if (done !== 1'b1) chk("apb_done", 1, 0);
  endtask
  task cmd(input logic [3:0] c, input logic [31:0] a);
    op(1, `SSP_A_ARG0, a);
    op(1, `SSP_A_CMD, {28'h0, c});
  endtask
  task stat(input logic [31:0] e);
    op(0, `SSP_A_STAT, 0);
    chk("stat", e, hr & 32'h37);
  endtask
  task rdat(input logic [31:0] a, input logic [7:0] e);
    cmd(SR_READ, a);
    op(0, `SSP_A_RDAT, 0);
    chk("rdat", {24'h0, e}, hr);
  endtask
  // array check: grant expected or not, two cycles for the pulse to land
  task ac(input logic [3:0] c, input logic [5:0] s, input logic g);
    int g0;
    g0 = gcnt;
    cmd(c, {10'h0, s, 16'h0});
    repeat (2) @(posedge clock);
    chk("grant", {31'h0, g}, 32'(gcnt - g0));
    if (g) chk("sector", {26'h0, s}, {26'h0, gsec});
  endtask
  task hw_reset();
    rst <= 1'b1;
    repeat (2) @(posedge clock);
    rst <= 1'b0;
    @(posedge clock);
  endtask
  initial begin
    repeat (16) @(posedge clock);
    rst <= 1'b0;
    por <= 1'b0;
    @(posedge clock);
    stat(32'h6);
    op(0, `SSP_A_CFG, 0);
    chk("cfg", 32'h400, hr);
    op(0, 12'h01c, 0);
    chk("slverr", 1, {31'h0, herr});
    chk("unmapped", 0, hr);
    ac(ARR_PROG, 6'd1, 1'b1);
    cmd(SR_ENTER, 32'h30000);
    stat(32'h7);
    foreach (rows[i]) begin
      op(1, `SSP_A_ARG1, {24'h0, rows[i].d});
      cmd(SR_PROG, {16'h3, rows[i].pa});
      stat(32'h7 | {27'h0, rows[i].pe, 4'h0});
      op(1, `SSP_A_STAT, 32'h10);
      rdat({16'h3, 6'h0, rows[i].ra}, rows[i].e);
    end
    rdat(32'h50020, 8'hff);
    op(0, `SSP_A_STAT, 0);
    chk("array_read", 1, {31'h0, hr[3]});
    rdat(32'h30500, 8'hff);
    op(1, `SSP_A_CFG, 0);
    op(1, `SSP_A_ARG1, 0);
    cmd(SR_PROG, 32'h30040);
    stat(32'h7);
    rdat(32'h30040, 8'hff);
    op(1, `SSP_A_CFG, 32'h400);
    op(0, `SSP_A_CFG, 0);
    chk("cfg", 0, hr);
    cmd(SR_EXIT, 0);
    stat(32'h6);
    cmd(DYN_SET, 32'h20000);
    ac(ARR_ERASE, 6'd2, 1'b0);
    stat(32'h26);
    op(1, `SSP_A_STAT, 32'h20);
    cmd(DYN_CLR, 32'h20000);
    ac(ARR_ERASE, 6'd2, 1'b1);
    cmd(DYN_SET, 32'h20000);
    cmd(PERS_PROG, 32'h40000);
    ac(ARR_PROG, 6'd4, 1'b0);
    stat(32'h16);
    op(1, `SSP_A_STAT, 32'h10);
    cmd(LOCK_CLR, 0);
    stat(32'h4);
    cmd(PERS_ERASE, 0);
    cmd(PERS_PROG, 32'h50000);
    stat(32'h34);
    op(1, `SSP_A_STAT, 32'h30);
    cmd(SOFT_RST, 0);
    stat(32'h4);
    hw_reset();
    stat(32'h6);
    ac(ARR_PROG, 6'd2, 1'b1);
    ac(ARR_PROG, 6'd4, 1'b0);
    ac(ARR_PROG, 6'd5, 1'b1);
    op(1, `SSP_A_STAT, 32'h10);
    cmd(PERS_ERASE, 0);
    ac(ARR_PROG, 6'd4, 1'b1);
    op(1, `SSP_A_PCFG, 0);
    op(0, `SSP_A_PCFG, 0);
    chk("pcfg", 0, hr);
    hw_reset();
    stat(32'h0);
    op(1, `SSP_A_ARG1, 0);
    cmd(PW_UNLOCK, 0);
    stat(32'h0);
    op(1, `SSP_A_ARG1, PW[63:32]);
    cmd(PW_UNLOCK, PW[31:0]);
    stat(32'h2);
    cmd(LOCK_CLR, 0);
    stat(32'h0);
    cmd(SR_ENTER, 32'h30000);
    op(1, `SSP_A_ARG1, 32'h3c);
    cmd(SR_PROG, 32'h30044);
    stat(32'h1);
    rdat(32'h30044, 8'h3c);
    tally_and_finish();
  end
endmodule
`default_nettype wire

// ### verilog/ssp_defines.svh
`ifndef SSP_DEFINES_SVH
`define SSP_DEFINES_SVH

// apb register offsets
`define SSP_PAW     12
`define SSP_A_CFG   12'h000
`define SSP_A_STAT  12'h004
`define SSP_A_ARG0  12'h008
`define SSP_A_ARG1  12'h00c
`define SSP_A_CMD   12'h010
`define SSP_A_RDAT  12'h014
`define SSP_A_PCFG  12'h018

// secure region geometry
`define SSP_SR_BYTES  1024
`define SSP_RND_BYTES 16
`define SSP_LOCK_BYTE 10'h010
`define SSP_ERASED    8'hff

// field positions
`define SSP_FRZ_BIT   10
`define SSP_OVL_BIT   0
`define SSP_LOCK_BIT  1
`define SSP_SCH_BIT   2
`define SSP_ARR_BIT   3
`define SSP_PERR_BIT  4
`define SSP_EERR_BIT  5
`define SSP_PCFG_BIT  0
`define SSP_SEC_LSB   16
`define SSP_CMD_W     4

`endif

// ### verilog/ssp_pkg.sv
package ssp_pkg;

  typedef enum logic [3:0] {
    CMD_NOP    = 4'h0,
    SR_ENTER   = 4'h1,
    SR_EXIT    = 4'h2,
    SR_PROG    = 4'h3,
    SR_READ    = 4'h4,
    DYN_SET    = 4'h5,
    DYN_CLR    = 4'h6,
    PERS_PROG  = 4'h7,
    PERS_ERASE = 4'h8,
    LOCK_CLR   = 4'h9,
    PW_UNLOCK  = 4'ha,
    SOFT_RST   = 4'hb,
    ARR_PROG   = 4'hc,
    ARR_ERASE  = 4'hd
  } ssp_cmd_t;

endpackage

// ### verilog/ssp_protect.sv
// The implementer's own choices: the address map and the APB register port.
`timescale 1ns/1ps
`default_nettype none
`include "ssp_defines.svh"

// Operation
// - 1024-byte one-time secure region, 32 regions of 32 bytes each lockable.
// - program of zeros into the 16 random bytes fails, program error set.
// - lock bytes 0x10-0x13, one bit per region; zero blocks programming.
// - bytes 0x14-0x1f reserved but programmable like any other byte.
// - whole region delivered as all ones except the random number.
// - freeze bit 10 cleared blocks all secure programming until reset.
// - with freeze clear, secure programming fails silently, no status.
// - overlay covers only the entered sector; outside range undefined.
// - host enters overlay before secure access; exit returns to array.
// - secure program like array program, repeatable, never erasable.
// - secure program ignores address bit 10 upward, aliasing in range.
// - protection scheme has no effect on the secure region.
// - sector refused for program or erase if either protect bit zero.
// - lock bit zero refuses program and erase of persistent bits.
// - persistent scheme: lock set on reset; soft reset leaves it.
// - persistent scheme: lock clear command only; no command sets it.
// - password scheme: lock clear on reset, set by matching password.
// - password scheme: lock clear command works after unlock.
// - scheme chosen permanently from one-time configuration bits.
// - persistent sector bits delivered erased, all sectors open.
// - one volatile lock bit guards all persistent sector bits.
// - dynamic set drives bit to zero, clear to one, unlimited.
// - dynamic bits return to unprotected on power or hardware reset.
// - persistent bit program or erase under lock aborts, error shown.
module ssp_protect
  import ssp_pkg::*;
#(
  parameter int           NSEC      = 64,
  // arbitrary value
  parameter logic [127:0] RAND_NUM  = 128'h0123456789abcdef0f1e2d3c4b5a6978,
  // arbitrary value
  parameter logic [63:0]  HIDDEN_PW = 64'h5a5a_3c3c_a5a5_c3c3
) (
  input  wire logic                 clock,     // 100 MHz
  input  wire logic                 rst,       // hardware reset
  input  wire logic                 por,       // power-on reset
  input  wire logic                 psel,      // apb select
  input  wire logic                 penable,   // apb enable
  input  wire logic                 pwrite,    // apb direction
  input  wire logic [`SSP_PAW-1:0]  paddr,     // apb address
  input  wire logic [31:0]          pwdata,    // apb write data
  output logic      [31:0]          prdata,    // apb read data
  output logic                      pready,    // apb ready
  output logic                      pslverr,   // apb error
  output logic                      arr_grant, // array op allowed
  output logic [$clog2(NSEC)-1:0]   arr_sector // sector of grant
);

  localparam int SECW = $clog2(NSEC);

  typedef struct packed {
    logic [`SSP_SR_BYTES-1:0][7:0] mem;
    logic [NSEC-1:0]               pers;
    logic [NSEC-1:0]               dyn;
    logic                          pcfg;
    logic                          lock;
    logic                          frz;
    logic                          ovl;
    logic [SECW-1:0]               osec;
    logic                          perr;
    logic                          eerr;
    logic                          arr;
    logic [31:0]                   arg0;
    logic [31:0]                   arg1;
    logic [7:0]                    rdat;
    logic [31:0]                   prdata;
    logic                          pready;
    logic                          pslverr;
    logic                          grant;
    logic [SECW-1:0]               gsec;
  } ssp_st_t;

  ssp_st_t   st_reg;
  ssp_st_t   st_next;
  ssp_cmd_t  cmd;
  logic      acc;
  logic      fire;
  logic [9:0]      sa;
  logic [7:0]      sd;
  logic [SECW-1:0] sec;
  logic [15:0]     ofs;
  logic [4:0]      rg;
  logic            lk;

  assign acc  = psel && penable && st_reg.pready;
  assign fire = acc && pwrite && paddr == `SSP_A_CMD;
  assign cmd  = ssp_cmd_t'(pwdata[`SSP_CMD_W-1:0]);
  // secure program uses only the low ten address bits
  assign sa   = st_reg.arg0[9:0];
  assign sd   = st_reg.arg1[7:0];
  assign sec  = st_reg.arg0[`SSP_SEC_LSB +: SECW];
  assign ofs  = st_reg.arg0[15:0];
  assign rg   = sa[9:5];
  assign lk   = st_reg.mem[`SSP_LOCK_BYTE + {8'h00, rg[4:3]}][rg[2:0]];

  always_comb begin
    logic        hit;
    logic [31:0] rd;
    hit = 1'b1;
    rd  = 32'h0000_0000;
    st_next = st_reg;
    unique case (paddr)
      `SSP_A_CFG:  rd[`SSP_FRZ_BIT] = st_reg.frz;
      `SSP_A_STAT: begin
        rd[`SSP_OVL_BIT]  = st_reg.ovl;
        rd[`SSP_LOCK_BIT] = st_reg.lock;
        rd[`SSP_SCH_BIT]  = st_reg.pcfg;
        rd[`SSP_ARR_BIT]  = st_reg.arr;
        rd[`SSP_PERR_BIT] = st_reg.perr;
        rd[`SSP_EERR_BIT] = st_reg.eerr;
      end
      `SSP_A_ARG0: rd = st_reg.arg0;
      `SSP_A_ARG1: rd = st_reg.arg1;
      `SSP_A_CMD:  rd = 32'h0000_0000;
      `SSP_A_RDAT: rd[7:0] = st_reg.rdat;
      `SSP_A_PCFG: rd[`SSP_PCFG_BIT] = st_reg.pcfg;
      default:     hit = 1'b0;
    endcase
    // zero-wait slave: ready in the first access cycle
    st_next.pready  = psel && !penable;
    st_next.pslverr = psel && !penable && !hit;
    st_next.grant   = 1'b0;
    if (psel && !penable) begin
      st_next.prdata = rd;
    end
    if (acc && pwrite && hit) begin
      unique case (paddr)
        `SSP_A_CFG: begin
          // freeze only clears; reset brings it back
          st_next.frz = st_reg.frz & pwdata[`SSP_FRZ_BIT];
        end
        `SSP_A_STAT: begin
          if (pwdata[`SSP_PERR_BIT]) st_next.perr = 1'b0;
          if (pwdata[`SSP_EERR_BIT]) st_next.eerr = 1'b0;
        end
        `SSP_A_ARG0: st_next.arg0 = pwdata;
        `SSP_A_ARG1: st_next.arg1 = pwdata;
        `SSP_A_PCFG: begin
          // one-time bit: can only be programmed to zero
          st_next.pcfg = st_reg.pcfg & pwdata[`SSP_PCFG_BIT];
        end
        default: ;
      endcase
    end
    // command events come after the clears, so a set wins
    if (fire) begin
      unique case (cmd)
        SR_ENTER: begin
          st_next.ovl  = 1'b1;
          st_next.osec = sec;
        end
        SR_EXIT: st_next.ovl = 1'b0;
        SR_PROG: begin
          // scheme and persistent lock play no part here
          if (!st_reg.ovl) begin
          end else if (!st_reg.frz) begin
          end else if (sa < 10'(`SSP_RND_BYTES)) begin
            if (sd != `SSP_ERASED) st_next.perr = 1'b1;
          end else if (lk) begin
            // bits only go 1 to 0; no erase path exists
            st_next.mem[sa] = st_reg.mem[sa] & sd;
          end
        end
        SR_READ: begin
          if (st_reg.ovl && sec == st_reg.osec) begin
            st_next.arr  = 1'b0;
            st_next.rdat = (ofs[15:10] == 6'h00) ?
                           st_reg.mem[ofs[9:0]] : `SSP_ERASED;
          end else begin
            // main array answers; flag tells the system so
            st_next.arr  = 1'b1;
            st_next.rdat = `SSP_ERASED;
          end
        end
        DYN_SET: st_next.dyn[sec] = 1'b0;
        DYN_CLR: st_next.dyn[sec] = 1'b1;
        PERS_PROG: begin
          if (st_reg.lock) st_next.pers[sec] = 1'b0;
          else st_next.perr = 1'b1;
        end
        PERS_ERASE: begin
          if (st_reg.lock) st_next.pers = '1;
          else st_next.eerr = 1'b1;
        end
        LOCK_CLR: st_next.lock = 1'b0;
        PW_UNLOCK: begin
          if (!st_reg.pcfg && {st_reg.arg1, st_reg.arg0} == HIDDEN_PW)
            st_next.lock = 1'b1;
        end
        SOFT_RST: begin
          // lock bit deliberately untouched
          st_next.ovl  = 1'b0;
          st_next.perr = 1'b0;
          st_next.eerr = 1'b0;
        end
        ARR_PROG, ARR_ERASE: begin
          if (st_reg.pers[sec] && st_reg.dyn[sec]) begin
            st_next.grant = 1'b1;
            st_next.gsec  = sec;
          end else if (cmd == ARR_PROG) begin
            st_next.perr = 1'b1;
          end else begin
            st_next.eerr = 1'b1;
          end
        end
        default: ;
      endcase
    end
    if (rst) begin
      st_next.dyn     = '1;
      st_next.lock    = st_reg.pcfg;
      st_next.frz     = 1'b1;
      st_next.ovl     = 1'b0;
      st_next.osec    = '0;
      st_next.perr    = 1'b0;
      st_next.eerr    = 1'b0;
      st_next.arr     = 1'b0;
      st_next.arg0    = 32'h0000_0000;
      st_next.arg1    = 32'h0000_0000;
      st_next.rdat    = 8'h00;
      st_next.prdata  = 32'h0000_0000;
      st_next.pready  = 1'b0;
      st_next.pslverr = 1'b0;
      st_next.grant   = 1'b0;
      st_next.gsec    = '0;
    end
    if (por) begin
      st_next      = '0;
      // delivered state: random number, rest erased
      st_next.mem  = {{(`SSP_SR_BYTES-`SSP_RND_BYTES){`SSP_ERASED}},
                      RAND_NUM};
      st_next.pers = '1;
      st_next.dyn  = '1;
      st_next.pcfg = 1'b1;
      st_next.lock = 1'b1;
      st_next.frz  = 1'b1;
    end
  end

  always_ff @(posedge clock) begin
    st_reg <= st_next;
  end

  assign prdata     = st_reg.prdata;
  assign pready     = st_reg.pready;
  assign pslverr    = st_reg.pslverr;
  assign arr_grant  = st_reg.grant;
  assign arr_sector = st_reg.gsec;

  default clocking cb @(posedge clock);
  endclocking
  default disable iff (rst || por);

  sequence s_prog;
    fire && cmd == SR_PROG && st_reg.ovl;
  endsequence

  sequence s_dyn_set;
    fire && cmd == DYN_SET;
  endsequence

  AST_FREEZE_SILENT: assert property (
    s_prog and !st_reg.frz |=> $stable(st_reg.mem) && !$rose(st_reg.perr))
    else $error("program changed data while frozen");

  AST_RAND_ERR: assert property (
    s_prog and st_reg.frz && sa < 10'(`SSP_RND_BYTES) && sd != 8'hff
    |=> st_reg.perr && $stable(st_reg.mem))
    else $error("random number program not refused");

  AST_REGION_LOCK: assert property (
    s_prog and !lk |=> $stable(st_reg.mem))
    else $error("locked region was programmed");

  AST_PROG_AND: assert property (
    s_prog and st_reg.frz && lk && sa >= 10'(`SSP_RND_BYTES)
    |=> st_reg.mem[$past(sa)] == ($past(st_reg.mem[sa]) & $past(sd)))
    else $error("secure program result wrong");

  AST_SECT_REFUSE: assert property (
    fire && cmd == ARR_PROG && !(st_reg.pers[sec] && st_reg.dyn[sec])
    |=> !arr_grant && st_reg.perr)
    else $error("protected sector granted");

  AST_PERS_LOCKED: assert property (
    fire && cmd == PERS_PROG && !st_reg.lock
    |=> $stable(st_reg.pers) && st_reg.perr)
    else $error("persistent bit changed under lock");

  AST_LOCK_STAYS: assert property (
    st_reg.pcfg && !st_reg.lock |=> !st_reg.lock [*2])
    else $error("persistent lock set by software");

  AST_PW_MISMATCH: assert property (
    fire && cmd == PW_UNLOCK && !st_reg.lock &&
    {st_reg.arg1, st_reg.arg0} != HIDDEN_PW |=> !st_reg.lock)
    else $error("wrong password unlocked");

  AST_DYN_SET: assert property (
    s_dyn_set |=> !st_reg.dyn[$past(sec)])
    else $error("dynamic bit not set");

  AST_SOFT_LOCK: assert property (
    fire && cmd == SOFT_RST |=> $stable(st_reg.lock) && !st_reg.ovl)
    else $error("soft reset changed lock");

  AST_APB_READY: assert property (
    psel && !penable |=> pready ##1 !pready)
    else $error("ready not one cycle after setup");

  AST_SLVERR_READY: assert property (
    pslverr |-> pready)
    else $error("error shown without ready");

  // only a reset may bring freeze back
  AST_FRZ_HOLD: assert property (
    !st_reg.frz |=> !st_reg.frz)
    else $error("freeze came back without reset");

  AST_NO_ERASE: assert property (
    (st_reg.mem & ~$past(st_reg.mem)) == '0)
    else $error("secure region bit went back to one");

  AST_RAND_KEEP: assert property (
    $stable(st_reg.mem[15:0]))
    else $error("random number bytes changed");

  AST_PERS_ERASE_LOCK: assert property (
    fire && cmd == PERS_ERASE && !st_reg.lock
    |=> $stable(st_reg.pers) && st_reg.eerr)
    else $error("persistent erase not refused under lock");

  sequence s_unlock_ok;
    fire && cmd == PW_UNLOCK && !st_reg.pcfg &&
    {st_reg.arg1, st_reg.arg0} == HIDDEN_PW;
  endsequence

  AST_PW_MATCH: assert property (
    s_unlock_ok |=> st_reg.lock)
    else $error("matching password did not unlock");

  AST_LOCK_CLEAR: assert property (
    fire && cmd == LOCK_CLR |=> !st_reg.lock)
    else $error("lock clear command had no effect");

  AST_OVL_READ: assert property (
    fire && cmd == SR_READ && !(st_reg.ovl && sec == st_reg.osec)
    |=> st_reg.arr && st_reg.rdat == 8'hff)
    else $error("read outside overlay not sent to array");

  AST_GRANT_SECTOR: assert property (
    fire && (cmd == ARR_PROG || cmd == ARR_ERASE) && st_reg.pers[sec] &&
    st_reg.dyn[sec] |=> arr_grant && arr_sector == $past(sec))
    else $error("open sector not granted");

  AST_DYN_CLR: assert property (
    fire && cmd == DYN_CLR |=> st_reg.dyn[$past(sec)])
    else $error("dynamic bit not cleared");

  // scheme bit is one-time: nothing short of power-on restores it
  AST_PCFG_ONCE: assert property (
    !st_reg.pcfg |=> !st_reg.pcfg)
    else $error("scheme bit returned to one");

  AST_RST_VOLATILE: assert property (disable iff (por)
    rst |=> (&st_reg.dyn) && st_reg.frz && st_reg.lock == st_reg.pcfg)
    else $error("hardware reset left volatile state");

endmodule

`default_nettype wire
